/* File: shared/spi_frame_params.svh */
// Purpose: Register offsets, field positions, reset values and timing of the serial port
// Assumes: 32-bit APB, byte addresses
// Notes: Definitions only
`ifndef SPI_FRAME_PARAMS_SVH
`define SPI_FRAME_PARAMS_SVH
`define OFS_PORT_CONTROL       12'h000
`define OFS_FRAME_CONTROL      12'h004
`define OFS_DATA_PORT          12'h008
`define OFS_FIFO_STATUS        12'h00C
`define CTL_SIZE_LSB           0
`define CTL_SIZE_MSB           4
`define CTL_ENABLE_BIT         5
`define RST_FRAME_SIZE_M1      5'h07
`define FC_RX_ORDER_LSB        4
`define FC_CMD_WAIT_BIT        6
`define FC_RX_LEVEL_LSB        7
`define FC_TX_LEVEL_LSB        10
`define FC_GAP_LSB             14
`define FC_TX_ORDER_LSB        18
`define FC_IN_DELAY_BIT        21
`define ST_TX_EMPTY_BIT        0
`define ST_TX_SPACE_BIT        1
`define ST_RX_DATA_BIT         2
`define ST_RX_FULL_BIT         3
`define ST_BUSY_BIT            4
`define LVL_CODE_1             3'h0
`define LVL_CODE_4             3'h1
`define LVL_CODE_8             3'h2
`define IN_DELAY_CYCLES        2
`endif

/* File: shared/spi_frame_pkg.sv */
// Purpose: Types shared by the serial port
// Assumes: Nothing
// Notes: Constants live in spi_frame_params.svh
package spi_frame_pkg;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_SHIFT = 2'h1,
		ST_GAP   = 2'h3
	} link_state_e;
	typedef logic [31:0] word_t;
endpackage

/* File: rtl/spi_frame_fifo_status.sv */
// Purpose: APB serial port master with transmit and receive FIFOs, ordering and status
// Assumes: Mode 0 framing, serial clock divided from clk_i, DEPTH a power of two
// Assumes: HALF_DIV of 5 or more when the input delay is used, else the sample is stale
// Notes: Read data is captured in the setup cycle, so status is one cycle old
`timescale 1ns/1ps
`include "spi_frame_params.svh"
module spi_frame_fifo_status #(
	parameter int DEPTH    = 8,
	parameter int HALF_DIV = 4
) (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             sclk_o,
	output logic             mosi_o,
	output logic             cs_n_o,
	input  wire logic        miso_i,
	output logic             rx_level_hit_o,
	output logic             tx_level_hit_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	localparam logic [7:0] HD = 8'(HALF_DIV - 1);
	localparam logic [7:0] PER = 8'(2 * HALF_DIV - 1);

	typedef struct packed {
		spi_frame_pkg::link_state_e st;
		logic [DEPTH-1:0][31:0] txm;
		logic [DEPTH-1:0][31:0] rxm;
		logic [AW-1:0] tx_wp;
		logic [AW-1:0] tx_rp;
		logic [CW-1:0] tx_cnt;
		logic [AW-1:0] rx_wp;
		logic [AW-1:0] rx_rp;
		logic [CW-1:0] rx_cnt;
		logic [4:0]    size_m1;
		logic          en;
		logic [1:0]    rx_ord;
		logic          cmd_wait;
		logic [2:0]    rx_lvl;
		logic [2:0]    tx_lvl;
		logic [3:0]    gap_cfg;
		logic [1:0]    tx_ord;
		logic          in_del;
		logic [31:0]   sh;
		logic [31:0]   rsr;
		logic [5:0]    bitc;
		logic [7:0]    ph;
		logic [4:0]    gap;
		logic          sclk;
		logic          cs_n;
		logic          mosi;
		logic [1:0]    sync;
		logic [1:0]    dly;
		logic [31:0]   prdata;
		logic          rd_ok;
	} state_s;

	state_s r;
	state_s next_r;

	function automatic spi_frame_pkg::word_t rev32(input spi_frame_pkg::word_t d);
		spi_frame_pkg::word_t o;
		o = '0;
		for (int i = 0; i < 32; i++) begin
			o[i] = d[31-i];
		end
		return o;
	endfunction

	function automatic spi_frame_pkg::word_t swap32(input spi_frame_pkg::word_t d);
		return {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction

	function automatic spi_frame_pkg::word_t brb(input spi_frame_pkg::word_t d);
		spi_frame_pkg::word_t o;
		o = '0;
		for (int i = 0; i < 32; i++) begin
			o[i] = d[(i & 24) + 7 - (i & 7)];
		end
		return o;
	endfunction

	// Left-justified image, shifted out MSB first
	function automatic spi_frame_pkg::word_t tx_map(input spi_frame_pkg::word_t d,
			input logic [1:0] o, input logic [5:0] nb);
		spi_frame_pkg::word_t m;
		logic [5:0] ls;
		ls = 6'(6'd32 - nb);
		m = d & (32'hFFFFFFFF >> ls);
		case (o)
			2'h0: return m << ls;
			2'h1: return swap32(m);
			2'h2: return brb(m) << ls;
			default: return rev32(m);
		endcase
	endfunction

	// Undo the transmit order on a right-justified capture
	function automatic spi_frame_pkg::word_t rx_map(input spi_frame_pkg::word_t d,
			input logic [1:0] o, input logic [5:0] nb);
		spi_frame_pkg::word_t m;
		logic [5:0] ls;
		ls = 6'(6'd32 - nb);
		m = d & (32'hFFFFFFFF >> ls);
		case (o)
			2'h0: return m;
			2'h1: return swap32(m) >> ls;
			2'h2: return brb(m);
			default: return rev32(m) >> ls;
		endcase
	endfunction

	function automatic logic lvl_hit(input logic [2:0] c, input logic [CW-1:0] n);
		case (c)
			`LVL_CODE_1: return n >= CW'(1);
			`LVL_CODE_4: return n >= CW'(4);
			`LVL_CODE_8: return n >= CW'(8);
			default: return 1'b0;
		endcase
	endfunction

	logic       setup;
	logic       acc_wr;
	logic       acc_rd;
	logic       mapped;
	logic       miso_use;
	logic       tx_push;
	logic       tx_pop;
	logic       rx_push;
	logic       rx_pop;
	logic [5:0] nbits;
	logic [31:0] st_word;

	assign setup = psel_i && !penable_i;
	assign acc_wr = psel_i && penable_i && pwrite_i;
	assign acc_rd = psel_i && penable_i && !pwrite_i;
	assign nbits = {1'b0, r.size_m1} + 6'h01;
	assign miso_use = r.in_del ? r.dly[1] : r.sync[1];
	assign st_word = {27'h0, (r.st != spi_frame_pkg::ST_IDLE) || (r.tx_cnt != '0),
		r.rx_cnt == FULL,
		r.rx_cnt != '0,
		r.tx_cnt != FULL,
		r.tx_cnt == '0};

	always_comb begin
		mapped = 1'b0;
		if (paddr_i == `OFS_PORT_CONTROL) begin
			mapped = 1'b1;
		end else if (paddr_i == `OFS_FRAME_CONTROL) begin
			mapped = 1'b1;
		end else if (paddr_i == `OFS_DATA_PORT) begin
			mapped = 1'b1;
		end else if (paddr_i == `OFS_FIFO_STATUS) begin
			mapped = 1'b1;
		end
	end

	always_comb begin
		next_r = r;
		tx_push = 1'b0;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		rx_pop = 1'b0;
		next_r.sync = {r.sync[0], miso_i};
		next_r.dly = {r.dly[0], r.sync[1]};
		// Read data is taken in setup so the access edge can pop without a wait
		if (setup) begin
			next_r.prdata = '0;
			next_r.rd_ok = 1'b0;
			if (paddr_i == `OFS_PORT_CONTROL) begin
				next_r.prdata = {26'h0, r.en, r.size_m1};
			end else if (paddr_i == `OFS_FRAME_CONTROL) begin
				next_r.prdata = {10'h0, r.in_del, 1'b0, r.tx_ord, r.gap_cfg, 1'b0,
					r.tx_lvl, r.rx_lvl, r.cmd_wait, r.rx_ord, 4'h0};
			end else if (paddr_i == `OFS_DATA_PORT) begin
				next_r.prdata = r.rxm[r.rx_rp];
				next_r.rd_ok = r.rx_cnt != '0;
			end else if (paddr_i == `OFS_FIFO_STATUS) begin
				next_r.prdata = st_word;
			end
		end
		if (acc_rd && paddr_i == `OFS_DATA_PORT && r.rd_ok) begin
			rx_pop = 1'b1;
			next_r.rx_rp = r.rx_rp + AW'(1);
		end
		if (acc_wr) begin
			if (paddr_i == `OFS_PORT_CONTROL) begin
				next_r.size_m1 = pwdata_i[`CTL_SIZE_MSB:`CTL_SIZE_LSB];
				next_r.en = pwdata_i[`CTL_ENABLE_BIT];
			end else if (paddr_i == `OFS_FRAME_CONTROL) begin
				next_r.rx_ord = pwdata_i[`FC_RX_ORDER_LSB +: 2];
				next_r.cmd_wait = pwdata_i[`FC_CMD_WAIT_BIT];
				next_r.rx_lvl = pwdata_i[`FC_RX_LEVEL_LSB +: 3];
				next_r.tx_lvl = pwdata_i[`FC_TX_LEVEL_LSB +: 3];
				next_r.gap_cfg = pwdata_i[`FC_GAP_LSB +: 4];
				next_r.tx_ord = pwdata_i[`FC_TX_ORDER_LSB +: 2];
				next_r.in_del = pwdata_i[`FC_IN_DELAY_BIT];
			end else if (paddr_i == `OFS_DATA_PORT && r.tx_cnt != FULL) begin
				tx_push = 1'b1;
				next_r.txm[r.tx_wp] = pwdata_i;
				next_r.tx_wp = r.tx_wp + AW'(1);
			end
		end
		case (r.st)
			spi_frame_pkg::ST_IDLE: begin
				if (r.en && r.tx_cnt != '0) begin
					tx_pop = 1'b1;
					next_r.tx_rp = r.tx_rp + AW'(1);
					next_r.sh = tx_map(r.txm[r.tx_rp], r.tx_ord, nbits);
					next_r.mosi = next_r.sh[31];
					next_r.cs_n = 1'b0;
					next_r.sclk = 1'b0;
					next_r.bitc = nbits;
					next_r.ph = '0;
					next_r.st = spi_frame_pkg::ST_SHIFT;
				end
			end
			spi_frame_pkg::ST_SHIFT: begin
				next_r.ph = r.ph + 8'h01;
				if (r.ph == HD) begin
					next_r.ph = '0;
					next_r.sclk = !r.sclk;
					if (!r.sclk) begin
						next_r.rsr = {r.rsr[30:0], miso_use};
					end else begin
						next_r.sh = r.sh << 1;
						next_r.mosi = r.sh[30];
						next_r.bitc = r.bitc - 6'h01;
						if (r.bitc == 6'h01) begin
							// Received frame is dropped if the FIFO is full
							if (r.rx_cnt != FULL) begin
								rx_push = 1'b1;
								next_r.rxm[r.rx_wp] = rx_map(r.rsr, r.rx_ord, nbits);
								next_r.rx_wp = r.rx_wp + AW'(1);
							end
							next_r.cs_n = 1'b1;
							next_r.mosi = 1'b0;
							next_r.gap = {1'b0, r.gap_cfg} + {4'h0, r.cmd_wait};
							next_r.st = spi_frame_pkg::ST_GAP;
						end
					end
				end
			end
			spi_frame_pkg::ST_GAP: begin
				if (r.gap == '0) begin
					next_r.st = spi_frame_pkg::ST_IDLE;
				end else if (r.ph == PER) begin
					next_r.ph = '0;
					next_r.gap = r.gap - 5'h01;
				end else begin
					next_r.ph = r.ph + 8'h01;
				end
			end
			default: begin
				next_r.st = spi_frame_pkg::ST_IDLE;
			end
		endcase
		next_r.tx_cnt = r.tx_cnt + CW'(tx_push) - CW'(tx_pop);
		next_r.rx_cnt = r.rx_cnt + CW'(rx_push) - CW'(rx_pop);
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			r <= '0;
			r.size_m1 <= `RST_FRAME_SIZE_M1;
			r.cs_n <= 1'b1;
			r.st <= spi_frame_pkg::ST_IDLE;
		end else begin
			r <= next_r;
		end
	end

	assign prdata_o = r.prdata;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !mapped;
	assign sclk_o = r.sclk;
	assign mosi_o = r.mosi;
	assign cs_n_o = r.cs_n;
	assign rx_level_hit_o = lvl_hit(r.rx_lvl, r.rx_cnt);
	assign tx_level_hit_o = lvl_hit(r.tx_lvl, r.tx_cnt);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_write_data;
		acc_wr && paddr_i == `OFS_DATA_PORT && r.tx_cnt != FULL;
	endsequence

	a_tx_push_count: assert property (s_write_data ##0 (r.st != spi_frame_pkg::ST_IDLE)
		|=> r.tx_cnt == $past(r.tx_cnt) + CW'(1))
		else $error("transmit write not counted");
	a_rx_pop_count: assert property (acc_rd && paddr_i == `OFS_DATA_PORT && r.rd_ok
		&& !rx_push |=> r.rx_cnt == $past(r.rx_cnt) - CW'(1))
		else $error("receive read did not remove element");
	a_status_capture: assert property (setup && paddr_i == `OFS_FIFO_STATUS
		|=> prdata_o[0] == ($past(r.tx_cnt) == '0) && prdata_o[1] == ($past(r.tx_cnt) != FULL))
		else $error("transmit flags wrong");
	a_rx_flags: assert property (setup && paddr_i == `OFS_FIFO_STATUS
		|=> prdata_o[2] == ($past(r.rx_cnt) != '0) && prdata_o[3] == ($past(r.rx_cnt) == FULL))
		else $error("receive flags wrong");
	a_busy_pending: assert property (r.tx_cnt != '0 || !cs_n_o |-> st_word[4])
		else $error("busy flag low while work pending");
	a_rx_trigger: assert property (r.rx_lvl == `LVL_CODE_4 |-> rx_level_hit_o == (r.rx_cnt > CW'(3)))
		else $error("receive trigger level wrong");
	a_tx_trigger: assert property (r.tx_lvl == `LVL_CODE_8 |-> tx_level_hit_o == (r.tx_cnt > CW'(7)))
		else $error("transmit trigger level wrong");
	a_input_delay: assert property (r.in_del && $past(r.in_del) |-> miso_use == $past(r.sync[1], 2))
		else $error("input delay not two cycles");
	a_frame_hold: assert property ($fell(cs_n_o) |-> !cs_n_o [*8])
		else $error("frame ended too early");
	a_gap_idle: assert property ($rose(cs_n_o) && r.gap != '0 |-> cs_n_o [*8])
		else $error("link not idle during wait");
	a_cmd_wait: assert property ($rose(cs_n_o) && $past(r.cmd_wait) |-> r.gap != '0)
		else $error("command wait not inserted");
endmodule

/* File: tb/spi_link_partner.sv */
// Purpose: Serial slave on the link, mode 0
// Assumes: Replies MSB-first from the low bits_i bits of reply_i
// Notes: A released line shows the inverse of its last bit
`timescale 1ns/1ps
module spi_link_partner (
	input  wire logic        sclk_i,
	input  wire logic        mosi_i,
	input  wire logic        cs_n_i,
	input  wire logic [31:0] reply_i,
	input  wire logic [5:0]  bits_i,
	output logic             miso_o,
	output logic [31:0]      heard_o
);
	int idx;
	initial begin
		miso_o = 1'h0;
		heard_o = '0;
	end
	always @(negedge cs_n_i) begin
		idx = bits_i - 1;
		heard_o = '0;
		miso_o = reply_i[idx];
	end
	// Sample on the rising serial edge, change on the falling one
	always @(posedge sclk_i) if (!cs_n_i) heard_o = {heard_o[30:0], mosi_i};
	always @(negedge sclk_i) begin
		if (!cs_n_i && idx > 0) begin
			idx = idx - 1;
			miso_o = reply_i[idx];
		end
	end
	always @(posedge cs_n_i) miso_o = ~miso_o;
endmodule

/* File: tb/tb_spi_frame_fifo_status.sv */
// Purpose: Self-checking bench for the serial port with FIFOs and status
// Assumes: HALF_DIV 5, DEPTH 8, partner in mode 0
// Notes: Half period of 5 lets the delayed input settle before the rising edge
// Notes: Each scenario drives APB and judges the result itself
`timescale 1ns/1ps
`include "spi_frame_params.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_spi_frame_fifo_status;
	localparam int HD = 5;
	logic        clk_i, rstn_i, psel_i, penable_i, pwrite_i, miso_i, err;
	logic        pready_o, pslverr_o, sclk_o, mosi_o, cs_n_o, rx_hit, tx_hit;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, reply, heard;
	logic [5:0]  nbits;
	int          error_cnt, comparisons, cyc;

	spi_frame_fifo_status #(.DEPTH(8), .HALF_DIV(HD)) i_spi_frame_fifo_status (
		.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .sclk_o(sclk_o), .mosi_o(mosi_o),
		.cs_n_o(cs_n_o), .miso_i(miso_i), .rx_level_hit_o(rx_hit), .tx_level_hit_o(tx_hit));
	spi_link_partner i_spi_link_partner (.sclk_i(sclk_o), .mosi_i(mosi_o), .cs_n_i(cs_n_o),
		.reply_i(reply), .bits_i(nbits), .miso_o(miso_i), .heard_o(heard));

	function automatic logic [31:0] fc(input logic [1:0] o, input logic cw,
		input logic [2:0] rl, input logic [2:0] tl, input logic [3:0] g,
		input logic [1:0] ro, input logic dl);
		return {10'h000, dl, 1'h0, o, g, 1'h0, tl, rl, cw, ro, 4'h0};
	endfunction
	function automatic logic [31:0] ctl(input logic en, input int n);
		return {26'h0, en, 5'(n - 1)};
	endfunction
	// Wire image of w: bits leave from the top of the result downwards
	function automatic logic [31:0] map_word(input logic [1:0] o, input int n,
		input logic [31:0] w);
		logic [31:0] r;
		r = '0;
		for (int i = 0; i < n; i++) begin
			case (o)
				2'h0: r[i] = w[i];
				2'h1: r[i] = w[(n / 8 - 1 - i / 8) * 8 + i % 8];
				2'h2: r[i] = w[(i / 8) * 8 + 7 - i % 8];
				default: r[i] = w[n - 1 - i];
			endcase
		end
		return r;
	endfunction

	// Ends one edge after the access, so the next setup never lands in the same step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		psel_i <= 1'h1;
		penable_i <= 1'h0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'h1;
		do @(posedge clk_i); while (pready_o !== 1'h1);
		q = prdata_o;
		err = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'h1, a, d, q);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		apb(1'h0, a, 32'h0, q);
	endtask
	task automatic idle();
		logic [31:0] q;
		q = 32'h0000_0010;
		while (q[`ST_BUSY_BIT] !== 1'h0) rd(`OFS_FIFO_STATUS, q);
	endtask

	task automatic t_reset();
		logic [31:0] q;
		rd(`OFS_FIFO_STATUS, q);
		`CHK(q, 32'h0000_0003)
		wr(`OFS_FIFO_STATUS, 32'hFFFF_FFFF);
		rd(`OFS_FIFO_STATUS, q);
		`CHK(q, 32'h0000_0003)
		rd(`OFS_DATA_PORT, q);
		`CHK(q, 32'h0000_0000)
		rd(12'h010, q);
		`CHK({err, q}, 33'h0_0000_0000 | 33'h1_0000_0000)
	endtask

	// Upper bits of the written word are junk on purpose
	task automatic t_order(input logic [1:0] o, input int n, input logic dl);
		logic [31:0] w, k, q;
		w = 32'hF1E2_D3C4;
		k = (n == 32) ? 32'hFFFF_FFFF : (32'h1 << n) - 32'h1;
		reply = map_word(o, n, w);
		nbits = 6'(n);
		wr(`OFS_FRAME_CONTROL, fc(o, 1'h0, 3'h0, 3'h0, 4'h0, o, dl));
		wr(`OFS_PORT_CONTROL, ctl(1'h1, n));
		wr(`OFS_DATA_PORT, w);
		idle();
		`CHK(heard & k, reply)
		rd(`OFS_DATA_PORT, q);
		`CHK(q, w & k)
	endtask

	task automatic t_fifo();
		logic [31:0] q;
		logic [2:0]  c[4] = '{3'h0, 3'h1, 3'h2, 3'h7};
		wr(`OFS_PORT_CONTROL, ctl(1'h0, 8));
		for (int i = 0; i < 9; i++) begin
			wr(`OFS_FRAME_CONTROL, fc(2'h0, 1'h0, 3'h2, 3'h1, 4'h0, 2'h0, 1'h0));
			`CHK(tx_hit, 1'(i >= 4))
			wr(`OFS_DATA_PORT, 32'h10 + i);
		end
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_FRAME_CONTROL, fc(2'h0, 1'h0, 3'h0, c[i], 4'h0, 2'h0, 1'h0));
			`CHK(tx_hit, 1'(i < 3))
		end
		rd(`OFS_FIFO_STATUS, q);
		`CHK(q, 32'h0000_0010)
		reply = 32'h3C;
		nbits = 6'h08;
		wr(`OFS_PORT_CONTROL, ctl(1'h1, 8));
		idle();
		`CHK(heard[7:0], 8'h17)
		rd(`OFS_FIFO_STATUS, q);
		`CHK(q, 32'h0000_000F)
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_FRAME_CONTROL, fc(2'h0, 1'h0, c[i], 3'h0, 4'h0, 2'h0, 1'h0));
			`CHK(rx_hit, 1'(i < 3))
		end
		wr(`OFS_FRAME_CONTROL, fc(2'h0, 1'h0, 3'h1, 3'h0, 4'h0, 2'h0, 1'h0));
		for (int i = 0; i < 8; i++) begin
			`CHK(rx_hit, 1'(i < 5))
			rd(`OFS_DATA_PORT, q);
			`CHK(q, 32'h0000_003C)
		end
		rd(`OFS_FIFO_STATUS, q);
		`CHK(q, 32'h0000_0003)
	endtask

	task automatic t_gap(input logic [3:0] g, input logic cw);
		logic [31:0] q;
		int          n, k;
		n = 0;
		k = (g + cw) * 2 * HD;
		wr(`OFS_FRAME_CONTROL, fc(2'h0, cw, 3'h0, 3'h0, g, 2'h0, 1'h0));
		wr(`OFS_PORT_CONTROL, ctl(1'h0, 8));
		wr(`OFS_DATA_PORT, 32'h0000_0081);
		wr(`OFS_PORT_CONTROL, ctl(1'h1, 8));
		// Second word lands while the first frame is shifting
		wr(`OFS_DATA_PORT, 32'h0000_0042);
		while (cs_n_o !== 1'h0) @(negedge clk_i);
		while (cs_n_o !== 1'h1) @(negedge clk_i);
		while (cs_n_o !== 1'h0) begin
			@(negedge clk_i);
			n++;
		end
		`CHK(1'(n >= k && n <= k + 3), 1'h1)
		@(posedge clk_i);
		idle();
		rd(`OFS_DATA_PORT, q);
		`CHK(q, 32'h0000_003C)
		rd(`OFS_DATA_PORT, q);
		`CHK(q, 32'h0000_003C)
	endtask

	task automatic final_report();
		$display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		clk_i = 1'h0;
		forever #12.5 clk_i = ~clk_i;
	end
	// Whole run needs well under this many cycles
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			final_report();
		end
	end
	initial begin
		{rstn_i, psel_i, penable_i, pwrite_i, err} = '0;
		{paddr_i, pwdata_i, reply, nbits, error_cnt, comparisons, cyc} = '0;
		repeat (16) @(posedge clk_i);
		rstn_i <= 1'h1;
		@(posedge clk_i);
		t_reset();
		t_order(2'h0, 32, 1'h0);
		t_order(2'h1, 32, 1'h0);
		t_order(2'h2, 16, 1'h0);
		t_order(2'h1, 24, 1'h1);
		t_order(2'h3, 8, 1'h1);
		t_order(2'h0, 4, 1'h0);
		t_order(2'h3, 4, 1'h0);
		t_order(2'h2, 32, 1'h0);
		t_fifo();
		t_gap(4'h3, 1'h0);
		t_gap(4'h3, 1'h1);
		final_report();
	end
endmodule
